// ===== verilog/i2mb_master.sv
// i2mb_master: apb-programmed i2c master with two port pairs and two buffers.
// assumes open-drain pads outside; oe high pulls the line low.
// Function
// - writing target address stores it and launches a transaction
// - 7-bit mode sends address bits 6:0, ignores 14:7
// - 10-bit mode uses bits 9:0, bits 14:10 head first byte
// - first burst moves the 5-bit count of bytes, one to sixteen
// - burst bit 5 gives direction after start, 1 reads
// - combined mode moves bits 12:8 byte count after repeated start
// - burst bit 13 gives direction after repeated start
// - burst bit 14 picks port a or port b lines
// - burst bit 15 selects combined transfer with repeated start
// - transmit port write stores low byte at its pointer
// - transmit autoincrement ignores pointer, uses internal count
// - receive port low byte returns buffer entry at pointer
// - receive autoincrement returns successive entries, ignores pointer
// - cycle count 5 to 200 sets scl half periods
// - control bit 8 marks shared bus with other masters
// - bit 9 lets slaves stretch scl; otherwise no scl sync
// - bit 10 tolerates a missing acknowledge
// - untolerated nack sets sticky bit 11, blocks until cleared by 1
// - control bit 12 selects 10-bit addressing
// - bit 13 ends with stop, else pauses holding the bus
// - read-only bit 14 shows the bus is paused
// - read-only bit 15 shows all transactions completed
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module i2mb_master
  import i2mb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DEPTH  = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sda_a_i,
  output logic                   sda_a_o,
  output logic                   sda_a_oe,
  input  wire logic              scl_a_i,
  output logic                   scl_a_o,
  output logic                   scl_a_oe,
  input  wire logic              sda_b_i,
  output logic                   sda_b_o,
  output logic                   sda_b_oe,
  input  wire logic              scl_b_i,
  output logic                   scl_b_o,
  output logic                   scl_b_oe
);
  if (ADDR_W < 9 || ADDR_W > 32 || DEPTH != (1 << PTR_W)) begin : g_chk
    $error("i2mb_master: unsupported ADDR_W or DEPTH");
  end

  logic [3:0]       ln;
  logic             sda_in, scl_in;
  logic [14:0]      tgt_q;
  logic [15:0]      burst_q, ctrl_q;
  logic             lock_q, txauto_q, rxauto_q;
  logic [PTR_W-1:0] txptr_q, rxptr_q, txw_q, rxr_q, txi_q, rxi_q;
  logic [7:0]       txm_q [DEPTH];
  logic [7:0]       rxm_q [DEPTH];
  i2mb_state_t      st_q;
  i2mb_seg_t        seg_q;
  logic [1:0]       ph_q;
  logic [3:0]       bit_q;
  logic [7:0]       sh_q, cnt_q, eff;
  logic [LEN_W-1:0] rem_q;
  logic             rd_q, b2_q, scl_q, sda_q, sda_d_q, port_q;
  logic             acc, hit_t, hit_b, hit_x, hit_r, hit_c, wr_tgt;
  logic             go, busy, stall, step, xmit, lost, ack_end, nack_set, store;
  logic [31:0]      rdval;

  i2mb_sync #(.W(4)) i2mb_sync_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({scl_b_i, sda_b_i, scl_a_i, sda_a_i}),
    .q       (ln)
  );
  assign sda_in = port_q ? ln[2] : ln[0];
  assign scl_in = port_q ? ln[3] : ln[1];

  // apb decode; zero wait states, unmapped access answers with an error
  assign acc     = psel & penable;
  assign hit_t   = (paddr == ADDR_W'(ADR_TARGET));
  assign hit_b   = (paddr == ADDR_W'(ADR_BURST));
  assign hit_x   = (paddr == ADDR_W'(ADR_TXBUF));
  assign hit_r   = (paddr == ADDR_W'(ADR_RXBUF));
  assign hit_c   = (paddr == ADDR_W'(ADR_CTRL));
  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_t | hit_b | hit_x | hit_r | hit_c);
  assign wr_tgt  = acc & pwrite & hit_t;

  function automatic logic [7:0] addr_byte(input logic [14:0] a, input logic w,
                                           input logic d);
    if (w) addr_byte = {a[14:10], a[9:8], d};
    else   addr_byte = {a[6:0], d};
  endfunction : addr_byte

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_q   <= 15'h0000;
      burst_q <= BURST_RST;
      ctrl_q  <= CTRL_RST;
    end else if (acc && pwrite) begin
      if (hit_t) tgt_q <= pwdata[14:0];
      if (hit_b) burst_q <= pwdata[15:0] & BURST_WMASK;
      if (hit_c) ctrl_q <= pwdata[15:0] & CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_q <= 1'b0;
    else if (nack_set) lock_q <= 1'b1;
    else if (acc && pwrite && hit_c && pwdata[LOCK_BIT]) lock_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txptr_q  <= '0;
      txauto_q <= 1'b0;
      txw_q    <= '0;
      for (int i = 0; i < DEPTH; i++) txm_q[i] <= 8'h00;
    end else if (acc && pwrite && hit_x) begin
      txptr_q  <= pwdata[PTR_LSB +: PTR_W];
      txauto_q <= pwdata[AUTO_BIT];
      if (pwdata[AUTO_BIT]) begin
        txm_q[txw_q] <= pwdata[7:0];
        txw_q        <= txw_q + 1'b1;
      end else begin
        txm_q[pwdata[PTR_LSB +: PTR_W]] <= pwdata[7:0];
      end
    end else if (go) begin
      txw_q <= '0;
    end
  end

  // receive read pointer advances per read in autoincrement mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxptr_q  <= '0;
      rxauto_q <= 1'b0;
      rxr_q    <= '0;
    end else if (go) begin
      rxr_q <= '0;
    end else if (acc && hit_r) begin
      if (pwrite) begin
        rxptr_q  <= pwdata[PTR_LSB +: PTR_W];
        rxauto_q <= pwdata[AUTO_BIT];
      end else if (rxauto_q) begin
        rxr_q <= rxr_q + 1'b1;
      end
    end
  end

  // read data mux; paused and complete flags
  always_comb begin
    rdval = 32'h0000_0000;
    if (hit_t) rdval[14:0] = tgt_q;
    if (hit_b) rdval[15:0] = burst_q;
    if (hit_x) rdval[15:0] = {txauto_q, 3'h0, txptr_q, txm_q[txauto_q ? txw_q : txptr_q]};
    if (hit_r) rdval[15:0] = {rxauto_q, 3'h0, rxptr_q, rxm_q[rxauto_q ? rxr_q : rxptr_q]};
    if (hit_c) rdval[15:0] = {st_q == S_IDLE || st_q == S_HOLD, st_q == S_HOLD,
                              ctrl_q[13:12], lock_q, ctrl_q[10:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rdval;
  end

  // half period, clamped to the least legal count
  assign eff   = (ctrl_q[CNT_LSB +: 8] < MIN_CYC) ? MIN_CYC : ctrl_q[CNT_LSB +: 8];
  assign busy  = (st_q == S_START) || (st_q == S_BIT) || (st_q == S_STOP);
  // wait while a slave holds scl low
  assign stall = ctrl_q[STRETCH_BIT] & scl_q & ~scl_in;
  assign step  = busy & (cnt_q == 8'h00) & ~stall;
  assign xmit  = ~((seg_q == SEG_DATA) & rd_q);
  // lost arbitration; only on a shared bus
  assign lost  = step & (st_q == S_BIT) & ph_q[0] & (bit_q < 4'h8) & xmit & sda_q
               & ~sda_in & ctrl_q[SHARED_BIT];
  assign ack_end  = step & (st_q == S_BIT) & ph_q[0] & (bit_q == 4'h8);
  assign nack_set = ack_end & xmit & sda_in & ~ctrl_q[TOL_BIT];
  assign store    = ack_end & ~xmit;
  // launch when free and not locked
  assign go       = wr_tgt & ((st_q == S_IDLE) || (st_q == S_HOLD)) & ~lock_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 8'h00;
    else if (go || step) cnt_q <= eff - 8'h01;
    else if (busy && !stall && cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxi_q <= '0;
      for (int i = 0; i < DEPTH; i++) rxm_q[i] <= 8'h00;
    end else if (go) begin
      rxi_q <= '0;
    end else if (store) begin
      rxm_q[rxi_q] <= sh_q;
      rxi_q        <= rxi_q + 1'b1;
    end
  end

  // sda leaves one cycle after scl so the slave sees data hold past the fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sda_d_q <= 1'b1;
    else sda_d_q <= sda_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE; ph_q <= 2'h0; bit_q <= 4'h0; sh_q <= 8'h00;
      seg_q <= SEG_ADDR1; rd_q <= 1'b0; b2_q <= 1'b0; rem_q <= '0;
      txi_q <= '0; scl_q <= 1'b1; sda_q <= 1'b1; port_q <= 1'b0;
    end else if (go) begin
      // start from idle, repeated start from a paused bus
      st_q   <= S_START;
      ph_q   <= (st_q == S_HOLD) ? 2'h0 : 2'h1;
      port_q <= burst_q[PORT_BIT];
      seg_q  <= SEG_ADDR1;
      rd_q   <= burst_q[DIR1_BIT];
      rem_q  <= burst_q[LEN1_LSB +: LEN_W];
      b2_q   <= 1'b0;
      bit_q  <= 4'h0;
      txi_q  <= '0;
      sh_q   <= addr_byte(pwdata[14:0], ctrl_q[WIDE_BIT], burst_q[DIR1_BIT]);
    end else if (lost) begin
      st_q  <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (step) begin
      unique case (st_q)
        S_START: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) scl_q <= 1'b1;
          else if (ph_q == 2'h1) sda_q <= 1'b0;
          else begin
            scl_q <= 1'b0;
            sda_q <= sh_q[7];
            st_q  <= S_BIT;
            ph_q  <= 2'h0;
          end
        end
        S_BIT: begin
          ph_q  <= {1'b0, ~ph_q[0]};
          scl_q <= ~ph_q[0];
          if (ph_q[0] && bit_q < 4'h8) begin
            bit_q <= bit_q + 4'h1;
            sh_q  <= {sh_q[6:0], xmit ? 1'b0 : sda_in};
            if (bit_q == 4'h7) sda_q <= xmit ? 1'b1 : (rem_q <= 5'h01);
            else sda_q <= xmit ? sh_q[6] : 1'b1;
          end else if (ph_q[0]) begin
            bit_q <= 4'h0;
            if (nack_set) begin
              st_q <= S_STOP; ph_q <= 2'h0; sda_q <= 1'b0;
            end else if (seg_q == SEG_ADDR1 && ctrl_q[WIDE_BIT] && !b2_q) begin
              seg_q <= SEG_ADDR2; sh_q <= tgt_q[7:0]; sda_q <= tgt_q[7];
            end else if (seg_q != SEG_DATA || rem_q > 5'h01) begin
              if (seg_q == SEG_DATA) rem_q <= rem_q - 5'h01;
              seg_q <= SEG_DATA;
              if (rd_q) sda_q <= 1'b1;
              else begin
                sh_q  <= txm_q[txi_q];
                sda_q <= txm_q[txi_q][7];
                txi_q <= txi_q + 1'b1;
              end
            // combined transfer; second count; second direction
            end else if (burst_q[COMB_BIT] && !b2_q) begin
              b2_q  <= 1'b1;
              rd_q  <= burst_q[DIR2_BIT];
              rem_q <= burst_q[LEN2_LSB +: LEN_W];
              seg_q <= SEG_ADDR1;
              sh_q  <= addr_byte(tgt_q, ctrl_q[WIDE_BIT], burst_q[DIR2_BIT]);
              st_q  <= S_START; ph_q <= 2'h0; sda_q <= 1'b1;
            // stop or pause holding scl low
            end else if (ctrl_q[STOP_BIT]) begin
              st_q <= S_STOP; ph_q <= 2'h0; sda_q <= 1'b0;
            end else begin
              st_q <= S_HOLD; sda_q <= 1'b1;
            end
          end
        end
        S_STOP: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) scl_q <= 1'b1;
          else if (ph_q == 2'h1) sda_q <= 1'b1;
          else st_q <= S_IDLE;
        end
        S_IDLE, S_HOLD: ;
      endcase
    end
  end

  // open-drain pads: only the selected pair is ever pulled low
  assign sda_a_o  = 1'b0;
  assign scl_a_o  = 1'b0;
  assign sda_b_o  = 1'b0;
  assign scl_b_o  = 1'b0;
  assign sda_a_oe = ~port_q & ~sda_d_q;
  assign scl_a_oe = ~port_q & ~scl_q;
  assign sda_b_oe = port_q & ~sda_d_q;
  assign scl_b_oe = port_q & ~scl_q;

  chk_launch_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_tgt && st_q == S_IDLE && !lock_q) |=> (st_q == S_START && ph_q == 2'h1))
    else $error("launch did not start");
  chk_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_tgt && st_q == S_IDLE && lock_q) |=> st_q == S_IDLE)
    else $error("locked master started");
  chk_seven_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (go && !ctrl_q[WIDE_BIT]) |=> sh_q[7:1] == tgt_q[6:0])
    else $error("seven-bit address byte wrong");
  chk_wide_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (go && ctrl_q[WIDE_BIT]) |=> sh_q[7:1] == tgt_q[14:8])
    else $error("ten-bit header byte wrong");
  chk_first_dir: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> (sh_q[0] == burst_q[DIR1_BIT] && rd_q == burst_q[DIR1_BIT]))
    else $error("direction bit wrong");
  chk_nack_lock: assert property (@(posedge pclk) disable iff (!presetn)
    nack_set |=> (lock_q && st_q == S_STOP))
    else $error("nack not locked");
  chk_hold_scl: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_HOLD) |-> (!scl_q && (scl_a_oe || scl_b_oe)))
    else $error("paused bus not held");
  chk_no_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && !go && !ctrl_q[STRETCH_BIT] && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("counter stalled without stretch");
  chk_half_min: assert property (@(posedge pclk) disable iff (!presetn)
    step |=> cnt_q >= MIN_CYC - 8'h01)
    else $error("half period too short");
  chk_port_route: assert property (@(posedge pclk) disable iff (!presetn)
    !port_q |-> (!sda_b_oe && !scl_b_oe))
    else $error("wrong port driven");
  chk_arb_lost: assert property (@(posedge pclk) disable iff (!presetn)
    (lost && !go) |=> (st_q == S_IDLE && sda_q && scl_q))
    else $error("bus not released on lost arbitration");

endmodule : i2mb_master

// ===== verilog/i2mb_pkg.sv
// i2mb_pkg: register map, field positions, reset values and states of the
// buffered i2c master. assumes a 32-bit apb slave with word-aligned registers.
package i2mb_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_TARGET = 8'h78;
  localparam logic [7:0]  IDX_BURST  = 8'h79;
  localparam logic [7:0]  IDX_TXBUF  = 8'h7A;
  localparam logic [7:0]  IDX_RXBUF  = 8'h7B;
  localparam logic [7:0]  IDX_CTRL   = 8'h7C;
  localparam logic [11:0] ADR_TARGET = {2'h0, IDX_TARGET, 2'h0};
  localparam logic [11:0] ADR_BURST  = {2'h0, IDX_BURST, 2'h0};
  localparam logic [11:0] ADR_TXBUF  = {2'h0, IDX_TXBUF, 2'h0};
  localparam logic [11:0] ADR_RXBUF  = {2'h0, IDX_RXBUF, 2'h0};
  localparam logic [11:0] ADR_CTRL   = {2'h0, IDX_CTRL, 2'h0};

  // burst_setup fields
  localparam int LEN_W      = 5;
  localparam int LEN1_LSB   = 0;
  localparam int DIR1_BIT   = 5;
  localparam int LEN2_LSB   = 8;
  localparam int DIR2_BIT   = 13;
  localparam int PORT_BIT   = 14;
  localparam int COMB_BIT   = 15;
  // buffer port fields
  localparam int PTR_W      = 4;
  localparam int PTR_LSB    = 8;
  localparam int AUTO_BIT   = 15;
  // bus_control_status fields
  localparam int CNT_LSB    = 0;
  localparam int SHARED_BIT = 8;
  localparam int STRETCH_BIT = 9;
  localparam int TOL_BIT    = 10;
  localparam int LOCK_BIT   = 11;
  localparam int WIDE_BIT   = 12;
  localparam int STOP_BIT   = 13;

  // reset values and write masks
  localparam logic [15:0] BURST_RST   = 16'h0101;
  localparam logic [15:0] CTRL_RST    = 16'h20C8;
  localparam logic [15:0] BURST_WMASK = 16'hFF3F;
  localparam logic [15:0] CTRL_WMASK  = 16'h37FF;
  localparam logic [7:0]  MIN_CYC     = 8'h05;

  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_STOP, S_HOLD} i2mb_state_t;
  typedef enum logic [1:0] {SEG_ADDR1, SEG_ADDR2, SEG_DATA} i2mb_seg_t;

endpackage : i2mb_pkg

// ===== verilog/i2mb_sync.sv
// i2mb_sync: three-flop input synchroniser for pin levels.
// assumes inputs are asynchronous to pclk; lines idle high after reset.
`timescale 1ns/1ns
module i2mb_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  if (W < 1) begin : g_chk
    $error("i2mb_sync: W must be at least one");
  end

  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;

  // a change counts only once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_q <= '1;
      ff2_q <= '1;
      ff3_q <= '1;
      q     <= '1;
    end else begin
      ff1_q <= d;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      for (int i = 0; i < W; i++) begin
        if (ff2_q[i] == ff3_q[i]) begin
          q[i] <= ff3_q[i];
        end
      end
    end
  end
endmodule : i2mb_sync

// ===== sim/i2mb_slave_model.sv
// i2mb_slave_model: behavioural i2c slave on one open-drain port pair.
// assumes resolved wire levels with pull-ups; logs every byte it receives while selected.
`timescale 1ns/1ns
module i2mb_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack_data,
  output logic      sda_oe
);
  logic [7:0] log_q [$];
  logic [7:0] sh = 8'h00;
  logic [7:0] txb = 8'hA0;
  logic       oe = 1'b0, first = 1'b0, sel = 1'b0, tx = 1'b0, go = 1'b0;
  int         bitn = 0;
  // no stretching: only sda is ever pulled
  assign sda_oe = oe;
  // start while scl high restarts the byte count
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      first = 1'b1;
      tx = 1'b0;
      txb = 8'hA0;
    end
  end
  always @(posedge scl) begin
    if (!tx && bitn >= 1 && bitn <= 8) sh = {sh[6:0], sda};
    if (tx && bitn == 9 && sda === 1'b1) tx = 1'b0;
  end
  always @(negedge scl) begin
    bitn = bitn + 1;
    if (bitn == 10) begin
      bitn = 1;
      oe = 1'b0;
      tx = tx | go;
      go = 1'b0;
    end
    if (tx && bitn == 9) txb = txb + 8'h01;
    if (tx) begin
      oe = (bitn < 9) && !txb[8 - bitn];
    end else if (bitn == 9) begin
      if (first) sel = (sh[7:1] == ADDR) || (sh[7:3] == 5'h1E);
      if (sel) log_q.push_back(sh);
      // data byte refused only when the bench asks
      oe = sel && (first || !nack_data);
      go = first && sh[0] && sel;
      first = 1'b0;
    end
  end
endmodule : i2mb_slave_model

// ===== sim/tb.sv
// tb: self-checking bench for the buffered i2c master, driven over apb.
// assumes pull-ups on both port pairs and one slave model on each pair.
`timescale 1ns/1ns
module tb;
  import i2mb_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, serr, ma_oe, mb_oe, na = 1'b0, grab = 1'b0, pull = 1'b0;
  logic        sda_a_oe, scl_a_oe, sda_b_oe, scl_b_oe;
  int          mismatches = 0, compares = 0, cycles = 0;
  time         last_r = 0, pmin = 0;
  // open drain: low while any party pulls, else the pull-up wins
  wire         sda_a = ~(sda_a_oe | ma_oe | grab);
  wire         scl_a = ~(scl_a_oe | pull);
  wire         sda_b = ~(sda_b_oe | mb_oe);
  wire         scl_b = ~scl_b_oe;
  i2mb_master i2mb_master_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sda_a_i(sda_a), .sda_a_o(), .sda_a_oe(sda_a_oe), .scl_a_i(scl_a), .scl_a_o(),
    .scl_a_oe(scl_a_oe), .sda_b_i(sda_b), .sda_b_o(), .sda_b_oe(sda_b_oe),
    .scl_b_i(scl_b), .scl_b_o(), .scl_b_oe(scl_b_oe));
  i2mb_slave_model #(.ADDR(7'h2A)) slave_a (
    .scl(scl_a), .sda(sda_a), .nack_data(na), .sda_oe(ma_oe));
  i2mb_slave_model #(.ADDR(7'h33)) slave_b (
    .scl(scl_b), .sda(sda_b), .nack_data(1'b0), .sda_oe(mb_oe));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end
  // shortest scl rise-to-rise spacing, one bit period
  always @(posedge scl_a) begin
    if ($time - last_r < pmin) pmin = $time - last_r;
    last_r = $time;
  end
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer plus an idle cycle, so strobes never toggle twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for pready; this loop has no bound of its own, only the bench timeout stops a hang
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask : rc
  // optionally launch, then poll the done flag with a bound
  task automatic run(input logic go, input logic [14:0] t);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0;
    if (go) wr(ADR_TARGET, {1'b0, t});
    while (q[15] !== 1'b1 && n < 3000) begin
      apb(1'b0, ADR_CTRL, 16'h0, q);
      n++;
    end
    chk({31'h0, q[15]}, 32'h00000001); // finished within the poll limit
  endtask : run
  task automatic chk_log(input logic p, input logic [31:0] e, input int n);
    logic [7:0] q [$];
    if (p) begin
      q = slave_b.log_q;
      slave_b.log_q.delete();
    end else begin
      q = slave_a.log_q;
      slave_a.log_q.delete();
    end
    chk(32'(q.size()), 32'(n));
    foreach (q[i]) chk({24'h0, q[i]}, {24'h0, e[8*(n-1-i) +: 8]});
  endtask : chk_log
  task automatic t_regs;
    rc(ADR_CTRL, 32'h0000A0C8); // done and count after reset
    rc(ADR_BURST, 32'h00000101); // counts reset to one
    rc(ADR_TARGET, 32'h00000000); // target clear
    rc(12'h000, 32'h00000000);
    chk({31'h0, serr}, 32'h00000001);
    wr(ADR_CTRL, 16'hFFFF);
    rc(ADR_CTRL, 32'h0000B7FF); // paused bit read-only
    wr(ADR_BURST, 16'hFFFF);
    rc(ADR_BURST, 32'h0000FF3F); // unused burst bits read zero
  endtask : t_regs
  task automatic t_wr7;
    wr(ADR_CTRL, 16'h2008);
    wr(ADR_TXBUF, 16'h025C);
    wr(ADR_TXBUF, 16'h8011);
    wr(ADR_TXBUF, 16'h8F22);
    wr(ADR_BURST, 16'h0003);
    pmin = 1000;
    run(1'b1, 15'h7FAA);
    chk_log(1'b0, 32'h5411225C, 4); // address then buffer order
    chk_log(1'b1, 32'h0, 0); // port b stays quiet
    chk(32'(pmin), 32'h000000A0); // bit period from count eight
    rc(ADR_CTRL, 32'h0000A008); // stopped, bus idle
  endtask : t_wr7
  task automatic t_comb;
    logic [31:0] q;
    wr(ADR_BURST, 16'hE301);
    run(1'b1, 15'h0033);
    chk_log(1'b1, 32'h00661167, 3); // restart header after one byte
    chk_log(1'b0, 32'h0, 0); // port a stays quiet
    wr(ADR_RXBUF, 16'h8000);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ADR_RXBUF, 16'h0, q);
      chk({24'h0, q[7:0]}, 32'h000000A0 + i); // successive entries
    end
    wr(ADR_RXBUF, 16'h0100);
    rc(ADR_RXBUF, 32'h000001A1); // entry at pointer
  endtask : t_comb
  task automatic t_hold;
    wr(ADR_CTRL, 16'h0005);
    wr(ADR_BURST, 16'h0022);
    run(1'b1, 15'h002A);
    rc(ADR_CTRL, 32'h0000C005); // paused and done
    chk({31'h0, scl_a}, 32'h00000000); // bus held, scl low
    chk_log(1'b0, 32'h00000055, 1); // read direction bit
    wr(ADR_CTRL, 16'h2005);
    wr(ADR_BURST, 16'h0001);
    run(1'b1, 15'h002A);
    chk_log(1'b0, 32'h00005411, 2); // resumed transfer
    rc(ADR_CTRL, 32'h0000A005); // idle after stop
    chk({30'h0, sda_a, scl_a}, 32'h00000003); // lines released
  endtask : t_hold
  task automatic t_nack;
    na <= 1'b1;
    wr(ADR_BURST, 16'h0002);
    run(1'b1, 15'h002A);
    chk_log(1'b0, 32'h00005411, 2); // stop right after refused byte
    rc(ADR_CTRL, 32'h0000A805); // lock flag set
    run(1'b1, 15'h002A);
    chk_log(1'b0, 32'h0, 0); // launch blocked
    wr(ADR_CTRL, 16'h2C05);
    rc(ADR_CTRL, 32'h0000A405); // lock cleared by a one
    run(1'b1, 15'h002A);
    chk_log(1'b0, 32'h00541122, 3); // refusals tolerated
    rc(ADR_CTRL, 32'h0000A405); // no lock when tolerated
    na <= 1'b0;
  endtask : t_nack
  task automatic t_wide;
    wr(ADR_CTRL, 16'h3003);
    wr(ADR_BURST, 16'h0001);
    pmin = 1000;
    run(1'b1, 15'h79BC);
    chk_log(1'b0, 32'h00F2BC11, 3); // header then low address
    chk(32'(pmin), 32'h00000064); // count below five clamped
  endtask : t_wide
  task automatic t_arb;
    wr(ADR_CTRL, 16'h2105);
    wr(ADR_TARGET, 16'h002A);
    // in the first address bit, while our bit is still low
    repeat (15) @(posedge pclk);
    grab <= 1'b1;
    run(1'b0, 15'h0);
    rc(ADR_CTRL, 32'h0000A105); // back off, no flag
    chk({30'h0, sda_a_oe, scl_a_oe}, 32'h00000000); // bus let go
    grab <= 1'b0;
    chk_log(1'b0, 32'h0, 0); // byte never finished
  endtask : t_arb
  // slave stretches the first low phase far beyond a half period
  task automatic t_stretch;
    wr(ADR_CTRL, 16'h2205);
    wr(ADR_TARGET, 16'h002A);
    repeat (10) @(posedge pclk);
    pull <= 1'b1;
    repeat (100) @(posedge pclk);
    pull <= 1'b0;
    run(1'b0, 15'h0);
    chk_log(1'b0, 32'h00005411, 2); // master waited out the stretch
  endtask : t_stretch
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_wr7();
    t_comb();
    t_hold();
    t_nack();
    t_wide();
    t_arb();
    t_stretch();
    conclude();
  end
endmodule : tb
